// File: src/chg_detect_cfg.svh
/*
  Timing constants and fixed values for the USB charger-detect control block.
  Assumes a 10 MHz core clock; counts are derived from times in their own unit.
*/
`ifndef CHG_DETECT_CFG_SVH
`define CHG_DETECT_CFG_SVH

`define CLK_PERIOD_NS 100
`define ATTACH_DEBOUNCE_MS 10
`define ATTACH_DEBOUNCE_CYC ((`ATTACH_DEBOUNCE_MS * 1000000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define PROBE_WINDOW_MS 100
`define PROBE_WINDOW_CYC ((`PROBE_WINDOW_MS * 1000000) / `CLK_PERIOD_NS)
`define DCP_MAX_OHM 200
`define OHM_WIDTH 12
`define TIMER_WIDTH 24
`define DET_SETTLE_US 1
`define DET_SETTLE_CYC ((`DET_SETTLE_US * 1000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// File: src/chg_detect_pkg.sv
/*
  Types for the USB charger-detect control block.
  Assumes the constants header is included by each user.
*/
package chg_detect_pkg;

  typedef enum logic [2:0] {
    ST_RESET    = 3'b000,
    ST_DEBOUNCE = 3'b001,
    ST_DETECT   = 3'b011,
    ST_POWER_UP = 3'b010,
    ST_ACTIVE   = 3'b110,
    ST_EMERG    = 3'b111,
    ST_SUSPEND  = 3'b101
  } chg_state_t;

endpackage

// File: src/sync_2ff.sv
/*
  Two-flip-flop level synchroniser for a bus of pin inputs.
  Assumes inputs are asynchronous levels; only the second stage is read.
*/
module sync_2ff #(
  parameter int WIDTH = 1
) (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] meta_ff;
  logic [WIDTH-1:0] sync_ff;

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      meta_ff <= '0;
      sync_ff <= '0;
    end else begin
      meta_ff <= async_i;
      sync_ff <= meta_ff;
    end
  end

  assign sync_o = sync_ff;

endmodule

// File: src/usb_charger_detect_control.sv
/*
  Charger-side control deciding who runs USB charger detection on D+/D-,
  with attach debounce, dedicated-charger classification, wake-up and fault return.
  Assumes analogue comparators and the resistance measurement arrive as pins
  (synchronised here), and host-side strobes come from core_clk_i logic.
*/
`include "chg_detect_cfg.svh"

// What this block does
// - Auto bit set: device classifies attached port
// - Load auto bit from OTP on power-up
// - Only selected party drives D+/D-
// - Leave reset only after 10 ms debounce
// - Dedicated charger only if resistance <= 200 ohm
// - Charger found: allow high current, power up
// - Attach while powered down triggers wake-up
// - Weak battery while idle: fault, reset mode
// - Supply collapse at start-up: fault, reset
// - Emergency mode blocks power-up, only charges
// - No charger, weak battery, host unpowered: 100 mA for 100 ms, then suspend
module usb_charger_detect_control
  import chg_detect_pkg::*;
#(
  parameter int DEBOUNCE_CYC = `ATTACH_DEBOUNCE_CYC,
  parameter int PROBE_CYC = `PROBE_WINDOW_CYC,
  parameter int SETTLE_CYC = `DET_SETTLE_CYC
) (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic vbus_valid_i,
  input wire logic [`OHM_WIDTH-1:0] dp_dm_ohm_i,
  input wire logic vdd_fault_i,
  input wire logic battery_ok_i,
  input wire logic battery_charged_i,
  input wire logic emergency_req_i,
  input wire logic usb_current_auto_detect_otp_i,
  input wire logic host_powered_i,
  input wire logic auto_detect_clr_i,
  input wire logic host_connected_i,
  output logic usb_current_auto_detect_o,
  output logic det_drive_o,
  output logic det_drive_oe_o,
  output logic phy_enable_ok_o,
  output logic high_current_o,
  output logic charge_only_o,
  output logic wake_o,
  output logic suspend_current_o,
  output logic supply_fault_o,
  output logic [2:0] state_o
);

  logic vbus_s;
  logic fault_s;
  logic batt_ok_s;
  logic batt_full_s;
  logic emerg_s;
  logic [`OHM_WIDTH-1:0] ohm_s;

  sync_2ff #(.WIDTH(`OHM_WIDTH + 5)) sync_2ff_i (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .async_i({dp_dm_ohm_i, vbus_valid_i, vdd_fault_i, battery_ok_i,
              battery_charged_i, emergency_req_i}),
    .sync_o({ohm_s, vbus_s, fault_s, batt_ok_s, batt_full_s, emerg_s})
  );

  chg_state_t state_ff, nxt_state;
  logic [`TIMER_WIDTH-1:0] timer_ff, nxt_timer;
  logic auto_ff, nxt_auto;
  logic high_ff, nxt_high;
  logic fault_ff, nxt_fault;
  logic wake_ff, nxt_wake;

  always_comb begin
    nxt_state = state_ff;
    nxt_timer = timer_ff;
    nxt_auto = auto_ff;
    nxt_high = high_ff;
    nxt_fault = fault_ff;
    nxt_wake = 1'b0;
    if (auto_detect_clr_i && host_powered_i) begin
      nxt_auto = 1'b0;
    end
    case (state_ff)
      ST_RESET: begin
        nxt_timer = '0;
        nxt_high = 1'b0;
        if (vbus_s) begin
          nxt_state = ST_DEBOUNCE;
        end
      end
      ST_DEBOUNCE: begin
        if (!vbus_s) begin
          nxt_state = ST_RESET;
        end else if (timer_ff == `TIMER_WIDTH'(DEBOUNCE_CYC - 1)) begin
          nxt_auto = usb_current_auto_detect_otp_i;
          nxt_fault = 1'b0;
          nxt_timer = '0;
          nxt_state = ST_DETECT;
        end else begin
          nxt_timer = timer_ff + 1'b1;
        end
      end
      ST_DETECT: begin
        nxt_timer = timer_ff + 1'b1;
        if (!auto_ff) begin
          nxt_state = ST_POWER_UP;
          nxt_timer = '0;
        end else if (timer_ff == `TIMER_WIDTH'(SETTLE_CYC)) begin
          nxt_high = (ohm_s <= `OHM_WIDTH'(`DCP_MAX_OHM));
          nxt_timer = '0;
          nxt_state = emerg_s ? ST_EMERG : ST_POWER_UP;
        end
      end
      ST_POWER_UP: begin
        nxt_wake = 1'b1;
        nxt_timer = timer_ff + 1'b1;
        if (host_powered_i) begin
          nxt_state = ST_ACTIVE;
        end else if (!high_ff && !batt_ok_s &&
                     timer_ff == `TIMER_WIDTH'(PROBE_CYC - 1)) begin
          nxt_state = ST_SUSPEND;
        end
      end
      ST_ACTIVE: begin
        nxt_timer = '0;
      end
      ST_EMERG: begin
        if (batt_full_s) begin
          nxt_state = ST_POWER_UP;
        end
      end
      ST_SUSPEND: begin
        if (host_connected_i) begin
          nxt_state = ST_ACTIVE;
        end
      end
      default: nxt_state = ST_RESET;
    endcase
    // Supply fault forces reset.
    // Reset mode withdraws the higher current at once, so a collapsed supply recovers.
    if (state_ff != ST_RESET && state_ff != ST_DEBOUNCE && (fault_s || !vbus_s)) begin
      nxt_state = ST_RESET;
      nxt_high = 1'b0;
      nxt_fault = fault_s | fault_ff;
    end
    if (state_ff == ST_ACTIVE && !host_powered_i && !batt_ok_s) begin
      nxt_state = ST_RESET;
      nxt_high = 1'b0;
      nxt_fault = 1'b1;
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_ff <= ST_RESET;
      timer_ff <= '0;
      auto_ff <= 1'b0;
      high_ff <= 1'b0;
      fault_ff <= 1'b0;
      wake_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      timer_ff <= nxt_timer;
      auto_ff <= nxt_auto;
      high_ff <= nxt_high;
      fault_ff <= nxt_fault;
      wake_ff <= nxt_wake;
    end
  end

  // Detection driver enable must drop combinationally so it can never overlap the PHY.
  // Single driver on D+/D-.
  // Drivers off without auto bit or VBUS.
  assign det_drive_oe_o = (state_ff == ST_DETECT) && auto_ff && vbus_s;
  assign det_drive_o = det_drive_oe_o;
  assign phy_enable_ok_o = !auto_ff;
  assign high_current_o = high_ff;
  assign charge_only_o = (state_ff == ST_EMERG);
  assign wake_o = wake_ff;
  assign suspend_current_o = (state_ff == ST_SUSPEND);
  assign supply_fault_o = fault_ff;
  assign usb_current_auto_detect_o = auto_ff;
  assign state_o = state_ff;

  sequence s_debounce_done;
    state_ff == ST_DEBOUNCE && nxt_state == ST_DETECT;
  endsequence

  a_drive_needs_auto: assert property (@(posedge core_clk_i) disable iff (rst_i)
    det_drive_oe_o |-> auto_ff && vbus_s)
    else $error("detection drivers active without auto bit or VBUS");
  a_single_driver: assert property (@(posedge core_clk_i) disable iff (rst_i)
    !(det_drive_oe_o && phy_enable_ok_o))
    else $error("device and transceiver both enabled on D+/D-");
  a_otp_loaded: assert property (@(posedge core_clk_i) disable iff (rst_i)
    s_debounce_done |=> auto_ff == $past(usb_current_auto_detect_otp_i))
    else $error("auto bit not loaded from OTP");
  a_debounce_time: assert property (@(posedge core_clk_i) disable iff (rst_i)
    s_debounce_done |-> timer_ff == `TIMER_WIDTH'(DEBOUNCE_CYC - 1))
    else $error("reset left before debounce time");
  a_dcp_class: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (state_ff == ST_DETECT && nxt_state != ST_DETECT && auto_ff && nxt_state != ST_RESET)
    |=> high_current_o == ($past(ohm_s) <= `OHM_WIDTH'(`DCP_MAX_OHM)))
    else $error("charger classification wrong");
  a_fault_reset: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (fault_s && state_ff inside {ST_DETECT, ST_POWER_UP, ST_ACTIVE})
    |=> state_ff == ST_RESET && supply_fault_o)
    else $error("supply fault did not return to reset");
  a_weak_idle: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (state_ff == ST_ACTIVE && !host_powered_i && !batt_ok_s)
    |=> state_ff == ST_RESET && supply_fault_o)
    else $error("weak battery while idle not handled");
  a_emerg_no_wake: assert property (@(posedge core_clk_i) disable iff (rst_i)
    state_ff == ST_EMERG |=> !wake_o)
    else $error("power-up raised during emergency charging");
  a_wake_on_attach: assert property (@(posedge core_clk_i) disable iff (rst_i)
    state_ff == ST_POWER_UP |=> wake_o)
    else $error("no wake-up after attach");
  a_clear_auto: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (auto_detect_clr_i && host_powered_i &&
     !(state_ff == ST_DEBOUNCE && nxt_state == ST_DETECT))
    |=> !usb_current_auto_detect_o)
    else $error("host clear of auto bit ignored");
  a_reset_no_high: assert property (@(posedge core_clk_i) disable iff (rst_i)
    state_ff == ST_RESET |-> !high_current_o)
    else $error("higher current allowed in reset mode");

endmodule

// File: tb/usb_port_model.sv
/*
  Model of the attached USB port: VBUS presence and the D+/D- resistance seen by the charger.
  Assumes the bench chooses when the port attaches and what resistance it presents.
*/
module usb_port_model (
  input wire logic attach_i,
  input wire logic [11:0] ohm_i,
  output logic vbus_valid_o,
  output logic [11:0] dp_dm_ohm_o
);
  timeunit 1ns;
  timeprecision 1ns;
  assign vbus_valid_o = attach_i;
  // open lines when absent
  // Nothing attached means floating lines, so the measurement reads open circuit.
  assign dp_dm_ohm_o = attach_i ? ohm_i : 12'hfff;
endmodule

// File: tb/usb_charger_detect_control_tb.sv
/*
  Self-checking bench for the charger-detect control block.
  Assumes shortened counts: 20 cycles of debounce, 50 of probe window.
*/
module usb_charger_detect_control_tb;
  import chg_detect_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int DBC = 20;
  logic core_clk_i = 1'b0, rst_i = 1'b1, attach = 1'b0, vbus, vdd_fault = 1'b0;
  logic bat_ok = 1'b1, bat_chg = 1'b0, emerg = 1'b0, otp = 1'b0;
  logic host_pw = 1'b0, clr = 1'b0, host_conn = 1'b0;
  logic [11:0] ohm = 12'h000, ohm_s;
  logic auto_o, oe_o, drv_o, phy_ok, hc_o, chg_only, wake, susp, fault_o;
  logic [2:0] state_o, prev_st = 3'h0;
  logic [3:0] q[$];
  int failures = 0, tests_run = 0, cyc = 0;

  usb_port_model usb_port_model_i (.attach_i(attach), .ohm_i(ohm), .vbus_valid_o(vbus),
    .dp_dm_ohm_o(ohm_s));
  usb_charger_detect_control #(.DEBOUNCE_CYC(DBC), .PROBE_CYC(50), .SETTLE_CYC(10))
    usb_charger_detect_control_i (.core_clk_i(core_clk_i), .rst_i(rst_i),
    .vbus_valid_i(vbus), .dp_dm_ohm_i(ohm_s), .vdd_fault_i(vdd_fault),
    .battery_ok_i(bat_ok), .battery_charged_i(bat_chg), .emergency_req_i(emerg),
    .usb_current_auto_detect_otp_i(otp), .host_powered_i(host_pw),
    .auto_detect_clr_i(clr), .host_connected_i(host_conn),
    .usb_current_auto_detect_o(auto_o), .det_drive_o(drv_o), .det_drive_oe_o(oe_o),
    .phy_enable_ok_o(phy_ok), .high_current_o(hc_o), .charge_only_o(chg_only),
    .wake_o(wake), .suspend_current_o(susp), .supply_fault_o(fault_o), .state_o(state_o));

  initial begin
    forever #50 core_clk_i = ~core_clk_i;
  end

  task automatic chk(input logic [7:0] seen, input logic [7:0] expv);
    tests_run++;
    if (seen !== expv) begin
      failures++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, expv);
    end
  endtask

  task automatic push_exp(input logic h, input chg_state_t s);
    q.push_back({h, s});
  endtask

  task automatic wait_st(input chg_state_t s, output int k);
    k = 0;
    while (state_o !== s && k < 400) begin
      @(negedge core_clk_i);
      k++;
    end
    if (state_o !== s) chk({5'h0, state_o}, {5'h0, s});
  endtask

  task automatic attach_port(input logic a, input logic [11:0] r);
    otp = a;
    ohm = r;
    attach = 1'b1;
    push_exp(1'b0, ST_DEBOUNCE);
    // The design passes through detection for one cycle even with the auto bit clear.
    push_exp(1'b0, ST_DETECT);
  endtask

  // Supply fault (weak battery with host unpowered when sup is 0) and detach together; the fault is expected to win.
  task automatic fault_out(input logic sup);
    int k;
    push_exp(1'b0, ST_RESET);
    vdd_fault = sup;
    bat_ok = sup;
    host_pw = 1'b0;
    attach = 1'b0;
    wait_st(ST_RESET, k);
    chk(fault_o, 1'b1);
    repeat (4) @(negedge core_clk_i);
    vdd_fault = 1'b0;
    bat_ok = 1'b1;
  endtask

  task test_done;
    $display("counts: %0d compares, %0d mismatches", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  always @(negedge core_clk_i) begin
    if (state_o !== prev_st) begin
      prev_st = state_o;
      if (q.size() == 0) chk(8'hff, {hc_o, state_o});
      else chk({hc_o, state_o}, q.pop_front());
    end
  end

  always @(posedge core_clk_i) begin
    cyc++;
    if (cyc == 6000) begin
      failures++;
      test_done;
    end
  end

  initial begin
    int k;
    void'($urandom(32'h0758));
    repeat (10) @(negedge core_clk_i);
    rst_i = 1'b0;
    @(negedge core_clk_i);
    attach_port(1'b1, 12'd200);
    push_exp(1'b1, ST_POWER_UP);
    push_exp(1'b1, ST_ACTIVE);
    wait_st(ST_DEBOUNCE, k);
    wait_st(ST_DETECT, k);
    chk(k[7:0], DBC);
    chk({auto_o, oe_o}, 2'b11);
    wait_st(ST_POWER_UP, k);
    @(negedge core_clk_i);
    chk(wake, 1'b1);
    host_pw = 1'b1;
    wait_st(ST_ACTIVE, k);
    clr = 1'b1;
    @(negedge core_clk_i);
    clr = 1'b0;
    host_conn = 1'b1;
    repeat (2) @(negedge core_clk_i);
    chk({auto_o, phy_ok, oe_o}, 3'b010);
    host_conn = 1'b0;
    fault_out(1'b0);
    $display("test charger_host_active done");
    bat_ok = 1'b0;
    attach_port(1'b1, 12'd201);
    push_exp(1'b0, ST_POWER_UP);
    push_exp(1'b0, ST_SUSPEND);
    wait_st(ST_SUSPEND, k);
    chk({hc_o, susp, chg_only}, 3'b010);
    bat_ok = 1'b1;
    host_pw = 1'b1;
    repeat (3) @(negedge core_clk_i);
    push_exp(1'b0, ST_ACTIVE);
    host_conn = 1'b1;
    wait_st(ST_ACTIVE, k);
    chk({susp, hc_o}, 2'b00);
    host_conn = 1'b0;
    fault_out(1'b1);
    $display("test weak_battery_suspend done");
    attach_port(1'b0, 12'd100);
    push_exp(1'b0, ST_POWER_UP);
    wait_st(ST_POWER_UP, k);
    chk({oe_o, phy_ok, hc_o}, 3'b010);
    fault_out(1'b1);
    $display("test phy_negotiates done");
    emerg = 1'b1;
    attach_port(1'b1, 12'd201 + 12'($urandom % 3895));
    push_exp(1'b0, ST_EMERG);
    wait_st(ST_EMERG, k);
    chk({chg_only, wake}, 2'b10);
    emerg = 1'b0;
    bat_chg = 1'b1;
    push_exp(1'b0, ST_POWER_UP);
    wait_st(ST_POWER_UP, k);
    bat_chg = 1'b0;
    fault_out(1'b1);
    $display("test emergency_charge done");
    test_done;
  end
endmodule
